// ---- acs_host.sv ----
// host-side partner: trigger pin and converter stimulus
`timescale 1ns/100ps
module acs_host (
    // from bench and device
    input  wire logic       i_clk,
    input  wire logic       i_fire,
    input  wire logic [3:0] i_chan,
    // to device
    output logic            o_trig_n,
    output logic [11:0]     o_adc_data,
    output logic            o_temp_done,
    output logic [11:0]     o_temp_data
);
    logic [2:0] low_r = 3'h0;
    logic [5:0] tick_r = 6'h00;
    // pin rests high, held low long enough to pass the synchronizer
    always_ff @(posedge i_clk) begin
        low_r  <= i_fire ? 3'h6 : low_r - {2'h0, low_r != 3'h0};
        tick_r <= tick_r + 6'h01;
    end
    assign o_trig_n    = low_r == 3'h0;
    // data carries the channel so every result slot is traceable
    assign o_adc_data  = {8'h8a, i_chan};
    assign o_temp_done = tick_r == 6'h3f;
    assign o_temp_data = 12'h123;
endmodule : acs_host

// ---- acs_pkg.sv ----
// constants, register map and types for the conversion sequencer
//
// Function
// - full-scale doubling bit selects 0..Vref or 0..2Vref, differential +-Vref or +-2Vref
// - out-of-range on channels 0-3 or temperature sets alarm flag and drives alarm low
// - single-shot converts each selected channel once, then idles for a new trigger
// - continuous mode rescans the selected group forever without new triggers
// - a cycle starts on external trigger falling edge or the software convert bit; code ignores the bit in single-shot while the ready flag is set
// - new trigger, mode change, channel-select or threshold write aborts the cycle at once
// - external edge while converting finishes the channel, ends the cycle, waits
// - sixteen holding registers load per channel, all copied to results at cycle end
// - single-ended results straight binary, differential results two's complement
// - single-shot: results updated sets the ready flag and pulls ready pin low
// - single-shot: result read or external trigger clears the flag, pin high
// - continuous: 1 us low pulse on ready pin, ready flag always zero
// - continuous rate set by rate bits, 500 ksps, divided by channel count; code adds two clock cycles (ST_DONE, ST_SYNC) per scan
// - single-shot rate follows triggers, capped by rate bits, up to 4 us sync
// - any rate code other than 00 sleeps the converter between conversions
// - rate codes give 0.375/2.375/6.375/14.375 us acquisition plus 1.625 us conversion
// - temperature converter continuously cycles two remote and one local sensor
// - 8-bit signed ideality value N, effective factor 1.008*300/(300-N)
package acs_pkg;

    // ==========================================================
    // register offsets
    localparam logic [7:0] REG_CFG0     = 8'h00;
    localparam logic [7:0] REG_CFG1     = 8'h01;
    localparam logic [7:0] REG_CHSEL0   = 8'h02;
    localparam logic [7:0] REG_CHSEL1   = 8'h03;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_IDEAL    = 8'h05;
    localparam logic [7:0] REG_THR_BASE = 8'h08;  // ch k low at +2k, high at +2k+1
    localparam logic [7:0] REG_TLIM     = 8'h10;  // three temperature high limits
    localparam logic [7:0] REG_RES_BASE = 8'h20;  // sixteen results
    localparam logic [7:0] REG_TEMP     = 8'h30;  // three temperature readings

    // ==========================================================
    // field positions
    localparam int CFG0_MODE_BIT   = 0;  // scan_mode_select: 1 continuous
    localparam int CFG0_SWTRIG_BIT = 1;  // software_convert_trigger, self clearing
    localparam int CFG0_FLAG_BIT   = 2;  // result_ready_flag, read only
    localparam int CFG0_DOUBLE_BIT = 3;  // full_scale_double

    // ==========================================================
    // reset values
    localparam logic [15:0] CHSEL0_RST = 16'hffff;
    localparam logic [1:0]  CHSEL1_RST = 2'h0;
    localparam logic [11:0] THR_LO_RST = 12'h000;
    localparam logic [11:0] THR_HI_RST = 12'hfff;
    localparam logic [11:0] TLIM_RST   = 12'h7ff;
    localparam logic [7:0]  IDEAL_RST  = 8'h00;

    // ==========================================================
    // timing
    localparam int CLK_NS      = 100;
    localparam int CONV_NS     = 1625;
    localparam int ACQ0_NS     = 375;
    localparam int ACQ1_NS     = 2375;
    localparam int ACQ2_NS     = 6375;
    localparam int ACQ3_NS     = 14375;
    localparam int PULSE_NS    = 1000;
    localparam int SYNC_MAX_NS = 4000;
    localparam int SYNC_MAX_CYC = SYNC_MAX_NS / CLK_NS;
    localparam logic [7:0] SYNC_CYC  = 8'(3 < SYNC_MAX_CYC ? 3 : SYNC_MAX_CYC);
    localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACQ0_CYC  = 8'((ACQ0_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACQ1_CYC  = 8'((ACQ1_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACQ2_CYC  = 8'((ACQ2_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [7:0] ACQ3_CYC  = 8'((ACQ3_NS + CLK_NS - 1) / CLK_NS);
    // conversion gets the remainder of the whole sample period so the rate is exact
    localparam logic [7:0] CONV_CYC  = 8'((ACQ0_NS + CONV_NS) / CLK_NS) - ACQ0_CYC;
    localparam logic [9:0] IDEAL_BASE = 10'd300;

    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SYNC = 3'b001,
        ST_ACQ  = 3'b010,
        ST_CONV = 3'b011,
        ST_DONE = 3'b100
    } acs_state_t;

endpackage : acs_pkg

// ---- acs_sequencer.sv ----
// conversion sequencer, result buffering, alarms and register port
`timescale 1ns/100ps
module acs_sequencer
    import acs_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    // register port
    input  wire logic [7:0]  i_addr,
    input  wire logic [15:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [15:0] o_rdata,
    // host handshake pins
    input  wire logic        i_external_trigger_n,
    output logic             o_result_ready_n,
    output logic             o_alarm_n,
    // converter core
    output logic [3:0]       o_adc_channel,
    output logic             o_adc_diff,
    output logic             o_adc_acquire,
    output logic             o_adc_convert,
    output logic             o_full_scale_double,
    output logic             o_inter_sample_sleep,
    input  wire logic [11:0] i_adc_data,
    // temperature converter
    output logic [1:0]       o_temp_select,
    output logic [9:0]       o_ideality_denom,
    input  wire logic        i_temp_done,
    input  wire logic [11:0] i_temp_data
);

    // ==========================================================
    // functions
    function automatic logic [4:0] next_chan(input logic [15:0] mask, input logic [4:0] from);
        logic [4:0] res;
        res = 5'h00;
        for (int i = 15; i >= 0; i--) begin
            if (mask[i] && 5'(i) >= from) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction : next_chan

    function automatic logic out_of_range(input logic [11:0] v, input logic [11:0] lo,
                                          input logic [11:0] hi, input logic sgn);
        if (sgn) begin
            return ($signed(v) < $signed(lo)) || ($signed(v) > $signed(hi));
        end
        return (v < lo) || (v > hi);
    endfunction : out_of_range

    function automatic logic [7:0] acq_cycles(input logic [1:0] code);
        case (code)
            2'h0:    return ACQ0_CYC;
            2'h1:    return ACQ1_CYC;
            2'h2:    return ACQ2_CYC;
            default: return ACQ3_CYC;
        endcase
    endfunction : acq_cycles

    // ==========================================================
    // register storage
    logic              scan_mode_select_r;
    logic              full_scale_double_r;
    logic [1:0]        sample_rate_select_r;
    logic [15:0]       chsel0_r;
    logic [1:0]        chsel1_r;
    logic [7:0]        ideal_r;
    logic [11:0]       thr_r [8];
    logic [11:0]       tlim_r [3];
    logic [11:0]       channel_holding_reg [16];
    logic [11:0]       result_r [16];
    logic [11:0]       temp_r [3];
    logic [6:0]        status_r;
    logic              result_ready_flag_r;
    logic [7:0]        pulse_cnt_r;
    logic [15:0]       rdata_r;

    acs_state_t        state_r;
    logic [7:0]        cnt_r;
    logic [3:0]        chan_r;
    logic              stop_after_r;

    // ==========================================================
    // access decode
    logic        cfg0_wr;
    logic        sw_trig;
    logic        mode_chg;
    logic        chsel_wr;
    logic        thr_wr;
    logic        res_rd;
    logic        busy;
    logic        converting;
    logic        ext_fall;
    logic        abort_now;
    logic        start_now;
    logic        conv_end;
    logic        copy_now;
    logic [15:0] eff_mask;
    logic [4:0]  first_ch;
    logic [4:0]  after_ch;
    logic        chan_diff;
    logic [11:0] conv_val;

    assign cfg0_wr    = i_wr && i_addr == REG_CFG0;
    assign sw_trig    = cfg0_wr && i_wdata[CFG0_SWTRIG_BIT];
    assign mode_chg   = cfg0_wr && i_wdata[CFG0_MODE_BIT] != scan_mode_select_r;
    assign chsel_wr   = i_wr && (i_addr == REG_CHSEL0 || i_addr == REG_CHSEL1);
    assign thr_wr     = i_wr && i_addr[7:3] == REG_THR_BASE[7:3];
    assign res_rd     = i_rd && i_addr[7:4] == REG_RES_BASE[7:4];
    assign busy       = state_r != ST_IDLE;
    assign converting = state_r == ST_ACQ || state_r == ST_CONV;

    // a differential pair converts on its even channel; the odd partner is skipped
    assign eff_mask  = chsel0_r & ~{12'h000, chsel1_r[1], 1'b0, chsel1_r[0], 1'b0};
    assign first_ch  = next_chan(eff_mask, 5'h00);
    assign after_ch  = next_chan(eff_mask, {1'b0, chan_r} + 5'h01);
    assign chan_diff = (chan_r == 4'h0 && chsel1_r[0]) || (chan_r == 4'h2 && chsel1_r[1]);
    // core delivers offset binary; flipping the sign bit gives two's complement
    assign conv_val  = chan_diff ? {~i_adc_data[11], i_adc_data[10:0]} : i_adc_data;

    // software trigger during a running cycle aborts; external edge only aborts outside a channel
    assign abort_now = mode_chg || chsel_wr || thr_wr || (sw_trig && busy)
                       || (ext_fall && busy && !converting);
    // a pending ready flag holds off a software start in single-shot mode
    assign start_now = !busy && !abort_now
                       && (ext_fall || (sw_trig && (scan_mode_select_r || !result_ready_flag_r)));
    assign conv_end  = state_r == ST_CONV && cnt_r == 8'h00 && !abort_now;
    assign copy_now  = state_r == ST_DONE && !abort_now;

    // ==========================================================
    // external trigger pin: three stages, edge counted once stages two and three agree
    logic trg_s1_r;
    logic trg_s2_r;
    logic trg_s3_r;
    logic trg_lvl_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trg_s1_r  <= 1'b1;
            trg_s2_r  <= 1'b1;
            trg_s3_r  <= 1'b1;
            trg_lvl_r <= 1'b1;
        end else begin
            trg_s1_r <= i_external_trigger_n;
            trg_s2_r <= trg_s1_r;
            trg_s3_r <= trg_s2_r;
            if (trg_s2_r == trg_s3_r) begin
                trg_lvl_r <= trg_s3_r;
            end
        end
    end

    assign ext_fall = trg_lvl_r && !trg_s2_r && !trg_s3_r;

    // ==========================================================
    // configuration registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            scan_mode_select_r   <= 1'b0;
            full_scale_double_r  <= 1'b0;
            sample_rate_select_r <= 2'h0;
            chsel0_r             <= CHSEL0_RST;
            chsel1_r             <= CHSEL1_RST;
            ideal_r              <= IDEAL_RST;
        end else if (i_wr) begin
            case (i_addr)
                REG_CFG0: begin
                    scan_mode_select_r  <= i_wdata[CFG0_MODE_BIT];
                    full_scale_double_r <= i_wdata[CFG0_DOUBLE_BIT];
                end
                REG_CFG1:   sample_rate_select_r <= i_wdata[1:0];
                REG_CHSEL0: chsel0_r <= i_wdata;
                REG_CHSEL1: chsel1_r <= i_wdata[1:0];
                REG_IDEAL:  ideal_r <= i_wdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 4; k++) begin
                thr_r[2*k]     <= THR_LO_RST;
                thr_r[2*k + 1] <= THR_HI_RST;
            end
            for (int k = 0; k < 3; k++) begin
                tlim_r[k] <= TLIM_RST;
            end
        end else if (i_wr) begin
            if (thr_wr) begin
                thr_r[i_addr[2:0]] <= i_wdata[11:0];
            end
            for (int k = 0; k < 3; k++) begin
                if (i_addr == REG_TLIM + 8'(k)) begin
                    tlim_r[k] <= i_wdata[11:0];
                end
            end
        end
    end

    // effective factor is 1.008*300/denominator; the core holds the fixed numerator
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ideality_denom <= IDEAL_BASE;
        end else begin
            o_ideality_denom <= IDEAL_BASE - {{2{ideal_r[7]}}, ideal_r};
        end
    end

    // ==========================================================
    // sequencer
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_r <= ST_IDLE;
            cnt_r   <= 8'h00;
            chan_r  <= 4'h0;
        end else if (abort_now) begin
            state_r <= ST_IDLE;
            cnt_r   <= 8'h00;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (start_now) begin
                        state_r <= ST_SYNC;
                        cnt_r   <= SYNC_CYC - 8'h01;
                    end
                end
                ST_SYNC: begin
                    if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else if (first_ch[4]) begin
                        state_r <= ST_ACQ;
                        chan_r  <= first_ch[3:0];
                        cnt_r   <= acq_cycles(sample_rate_select_r) - 8'h01;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_ACQ: begin
                    if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else begin
                        state_r <= ST_CONV;
                        cnt_r   <= CONV_CYC - 8'h01;
                    end
                end
                ST_CONV: begin
                    if (cnt_r != 8'h00) begin
                        cnt_r <= cnt_r - 8'h01;
                    end else if (stop_after_r) begin
                        state_r <= ST_IDLE;
                    end else if (after_ch[4]) begin
                        state_r <= ST_ACQ;
                        chan_r  <= after_ch[3:0];
                        cnt_r   <= acq_cycles(sample_rate_select_r) - 8'h01;
                    end else begin
                        state_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    if (scan_mode_select_r) begin
                        state_r <= ST_SYNC;
                        cnt_r   <= 8'h00;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || state_r == ST_IDLE) begin
            stop_after_r <= 1'b0;
        end else if (ext_fall && converting) begin
            stop_after_r <= 1'b1;
        end
    end

    // ==========================================================
    // double-buffered results
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int k = 0; k < 16; k++) begin
                channel_holding_reg[k] <= 12'h000;
                result_r[k]            <= 12'h000;
            end
        end else begin
            if (conv_end) begin
                channel_holding_reg[chan_r] <= conv_val;
            end
            if (copy_now) begin
                for (int k = 0; k < 16; k++) begin
                    result_r[k] <= channel_holding_reg[k];
                end
            end
        end
    end

    // ==========================================================
    // ready handshake; a new result beats a clearing read in the same cycle
    always_ff @(posedge i_clk) begin
        if (i_rst || scan_mode_select_r) begin
            result_ready_flag_r <= 1'b0;
        end else if (copy_now) begin
            result_ready_flag_r <= 1'b1;
        end else if (res_rd || ext_fall) begin
            result_ready_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pulse_cnt_r <= 8'h00;
        end else if (copy_now && scan_mode_select_r) begin
            pulse_cnt_r <= PULSE_CYC;
        end else if (pulse_cnt_r != 8'h00) begin
            pulse_cnt_r <= pulse_cnt_r - 8'h01;
        end
    end

    assign o_result_ready_n = !(result_ready_flag_r || pulse_cnt_r != 8'h00);

    // ==========================================================
    // temperature sensors, visited in turn
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_temp_select <= 2'h0;
            for (int k = 0; k < 3; k++) begin
                temp_r[k] <= 12'h000;
            end
        end else if (i_temp_done) begin
            temp_r[o_temp_select] <= i_temp_data;
            o_temp_select <= (o_temp_select == 2'h2) ? 2'h0 : o_temp_select + 2'h1;
        end
    end

    // ==========================================================
    // alarms: sticky, cleared by reading status; a new event wins over the clear
    logic [6:0] alarm_set;

    always_comb begin
        alarm_set = 7'h00;
        if (conv_end && chan_r < 4'h4) begin
            alarm_set[chan_r[1:0]] = out_of_range(conv_val, thr_r[{chan_r[1:0], 1'b0}],
                                                  thr_r[{chan_r[1:0], 1'b1}], chan_diff);
        end
        if (i_temp_done && o_temp_select != 2'h3) begin
            alarm_set[3'h4 + {1'b0, o_temp_select}] = out_of_range(i_temp_data, 12'h800,
                                                  tlim_r[o_temp_select], 1'b1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            status_r <= 7'h00;
        end else if (i_rd && i_addr == REG_STATUS) begin
            status_r <= alarm_set;
        end else begin
            status_r <= status_r | alarm_set;
        end
    end

    assign o_alarm_n = ~|status_r;

    // ==========================================================
    // read port, data one cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_rd) begin
            rdata_r <= 16'h0000;
        end else if (i_addr[7:4] == REG_RES_BASE[7:4]) begin
            rdata_r <= {4'h0, result_r[i_addr[3:0]]};
        end else if (i_addr[7:3] == REG_THR_BASE[7:3]) begin
            rdata_r <= {4'h0, thr_r[i_addr[2:0]]};
        end else begin
            case (i_addr)
                REG_CFG0:   rdata_r <= {12'h000, full_scale_double_r, result_ready_flag_r,
                                        1'b0, scan_mode_select_r};
                REG_CFG1:   rdata_r <= {14'h0000, sample_rate_select_r};
                REG_CHSEL0: rdata_r <= chsel0_r;
                REG_CHSEL1: rdata_r <= {14'h0000, chsel1_r};
                REG_STATUS: rdata_r <= {9'h000, status_r};
                REG_IDEAL:  rdata_r <= {8'h00, ideal_r};
                REG_TLIM:   rdata_r <= {4'h0, tlim_r[0]};
                REG_TLIM + 8'h01: rdata_r <= {4'h0, tlim_r[1]};
                REG_TLIM + 8'h02: rdata_r <= {4'h0, tlim_r[2]};
                REG_TEMP:   rdata_r <= {4'h0, temp_r[0]};
                REG_TEMP + 8'h01: rdata_r <= {4'h0, temp_r[1]};
                REG_TEMP + 8'h02: rdata_r <= {4'h0, temp_r[2]};
                default:    rdata_r <= 16'h0000;
            endcase
        end
    end

    assign o_rdata = rdata_r;

    // ==========================================================
    // converter core controls
    assign o_adc_channel       = chan_r;
    assign o_adc_diff          = chan_diff;
    assign o_adc_acquire       = state_r == ST_ACQ;
    assign o_adc_convert       = state_r == ST_CONV;
    assign o_full_scale_double = full_scale_double_r;
    // sleep while idle or in the stretched part of acquisition; the last minimum
    // acquisition window stays awake so the sample settles
    assign o_inter_sample_sleep = sample_rate_select_r != 2'h0
                                  && (state_r == ST_IDLE || (state_r == ST_ACQ && cnt_r >= ACQ0_CYC));

endmodule : acs_sequencer

// ---- acs_sva.sv ----
// checker for the sequencer port timing
`timescale 1ns/100ps
module acs_sva (
    // clock, reset and register port
    input wire logic        i_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    // observed outputs
    input wire logic        o_result_ready_n,
    input wire logic        o_alarm_n,
    input wire logic        o_adc_acquire,
    input wire logic        o_adc_convert,
    input wire logic        o_inter_sample_sleep
);
    logic       mode_r;
    logic [1:0] rate_r;
    logic [7:0] acq_r, conv_r, lim;
    // shadow copies of mode and rate, the properties depend on them
    always_ff @(posedge i_clk) begin
        if (i_rst) mode_r <= 1'b0;
        else if (i_wr && i_addr == 8'h00) mode_r <= i_wdata[0];
        if (i_rst) rate_r <= 2'h0;
        else if (i_wr && i_addr == 8'h01) rate_r <= i_wdata[1:0];
        acq_r  <= o_adc_acquire ? acq_r + 8'h01 : 8'h00;
        conv_r <= o_adc_convert ? conv_r + 8'h01 : 8'h00;
    end
    assign lim = rate_r == 2'h0 ? 8'h04 : rate_r == 2'h1 ? 8'h18 : rate_r == 2'h2 ? 8'h40 : 8'h90;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    rst_idle_a: assert property (disable iff (1'b0) i_rst |=> o_result_ready_n && o_alarm_n)
        else $error("pins active after reset");
    rd_clear_a: assert property (i_rd && i_addr[7:4] == 4'h2 && !mode_r && !o_adc_convert
        && !$past(o_adc_convert) |=> o_result_ready_n)
        else $error("ready not cleared by result read");
    nap_off_a: assert property (rate_r == 2'h0 && $past(rate_r) == 2'h0 |-> !o_inter_sample_sleep)
        else $error("nap at full rate");
    nap_on_a: assert property ($rose(o_adc_acquire) && rate_r != 2'h0 |-> ##[1:6] o_inter_sample_sleep)
        else $error("no nap at reduced rate");
    acq_max_a: assert property (o_adc_acquire |-> acq_r < lim)
        else $error("acquisition too long");
    acq_len_a: assert property ($fell(o_adc_acquire) && o_adc_convert |-> acq_r == lim)
        else $error("acquisition length wrong");
    conv_max_a: assert property (o_adc_convert |-> conv_r < 8'h10)
        else $error("conversion too long");
    pulse_len_a: assert property ($fell(o_result_ready_n) && mode_r |->
        !o_result_ready_n [*8] ##1 !o_result_ready_n [*2] ##1 o_result_ready_n)
        else $error("ready pulse length wrong");
    cover property (mode_r && $fell(o_result_ready_n));
    cover property (!mode_r && $fell(o_result_ready_n));
    cover property (o_inter_sample_sleep && o_adc_acquire);
endmodule : acs_sva
bind acs_sequencer acs_sva u_sva (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_result_ready_n,
    .o_alarm_n, .o_adc_acquire, .o_adc_convert, .o_inter_sample_sleep);

// ---- acs_tb.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
module testbench;
    import acs_pkg::*;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, fire = 1'b0;
    logic [7:0]  i_addr = 8'h00;
    logic [15:0] i_wdata = 16'h0000, o_rdata;
    logic        i_external_trigger_n, o_result_ready_n, o_alarm_n, o_adc_diff, o_adc_acquire;
    logic        o_adc_convert, o_full_scale_double, o_inter_sample_sleep, i_temp_done;
    logic [3:0]  o_adc_channel;
    logic [1:0]  o_temp_select;
    logic [9:0]  o_ideality_denom;
    logic [11:0] i_adc_data, i_temp_data;
    int          err_total = 0, n_tests = 0, cyc = 0;
    always #50 i_clk = ~i_clk;
    acs_sequencer dut (.*);
    acs_host host (.i_clk, .i_fire(fire), .i_chan(o_adc_channel), .o_trig_n(i_external_trigger_n),
                   .o_adc_data(i_adc_data), .o_temp_done(i_temp_done), .o_temp_data(i_temp_data));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin err_total++; $display("Error at %0t: got %h expected %h", $time, got, exp); end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_addr <= a; i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask : rd
    task automatic wait_rdy();
        for (int k = 0; k < 3000 && o_result_ready_n !== 1'b0; k++) @(posedge i_clk) #1;
        chk({15'h0, o_result_ready_n}, 16'h0000);
    endtask : wait_rdy
    task automatic pulse();
        @(posedge i_clk) fire <= 1'b1;
        @(posedge i_clk) fire <= 1'b0;
    endtask : pulse
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    // a hang ends the run as a mismatch
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 20000) begin err_total++; wrap_up(); end
    end
    // ==========================================================
    // tests
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(REG_CFG0, 16'h0000);
        chk({15'h0, o_result_ready_n}, 16'h0001);
        rd(8'hff, 16'h0000);
        wr(REG_CFG0, 16'h0008);
        #1 chk({15'h0, o_full_scale_double}, 16'h0001);
        wr(REG_IDEAL, 16'h00ff);
        @(posedge i_clk) #1 chk({6'h0, o_ideality_denom}, 16'h012d);
        $display("test setup done");
        wr(REG_CFG1, 16'h0001);
        wr(REG_CHSEL1, 16'h0001);
        #1 chk({15'h0, o_adc_diff}, 16'h0001);
        wr(REG_CHSEL0, 16'h0011);
        wr(REG_CFG0, 16'h0002);
        wait_rdy();
        rd(REG_CFG0, 16'h0004);
        wr(REG_CFG0, 16'h0002);
        repeat (6) @(posedge i_clk);
        #1 chk({15'h0, o_adc_acquire}, 16'h0000);
        rd(REG_RES_BASE, 16'h00a0);
        rd(REG_RES_BASE + 8'h04, 16'h08a4);
        repeat (100) @(posedge i_clk);
        #1 chk({14'h0, o_adc_acquire, o_result_ready_n}, 16'h0001);
        $display("test single done");
        wr(REG_CHSEL1, 16'h0000);
        wr(REG_CHSEL0, 16'h0004);
        wr(REG_CFG1, 16'h0003);
        pulse();
        wait_rdy();
        wr(REG_CFG1, 16'h0002);
        pulse();
        repeat (6) @(posedge i_clk);
        #1 chk({15'h0, o_result_ready_n}, 16'h0001);
        wait_rdy();
        rd(REG_RES_BASE + 8'h02, 16'h08a2);
        rd(REG_TEMP, 16'h0123);
        $display("test external done");
        wr(REG_CFG1, 16'h0000);
        wr(REG_CHSEL0, 16'h0001);
        wr(REG_CFG0, 16'h0001);
        wr(REG_CFG0, 16'h0003);
        wait_rdy();
        repeat (12) @(posedge i_clk);
        wait_rdy();
        rd(REG_CFG0, 16'h0001);
        wr(REG_THR_BASE, 16'h0000);
        repeat (30) @(posedge i_clk) #1 chk({14'h0, o_adc_acquire, o_adc_convert}, 16'h0000);
        $display("test continuous done");
        wr(REG_CFG0, 16'h0000);
        wr(REG_THR_BASE + 8'h01, 16'h0100);
        wr(REG_CFG0, 16'h0002);
        wait_rdy();
        chk({15'h0, o_alarm_n}, 16'h0000);
        rd(REG_STATUS, 16'h0001);
        $display("test alarm done");
        wrap_up();
    end
endmodule : testbench
